/* logic/tcp_pkg.sv */
// shared constants and types for the timer/counter with prescaler
package tcp_pkg;

  // ==============================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int TOSC_NS       = 10;
  localparam int TOSC_CYCLES   = (TOSC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] PH_Q2 = 2'h1;
  localparam logic [1:0] PH_Q4 = 2'h3;
  localparam logic [1:0] WR_INHIBIT_CYCLES = 2'h2;

  // ==============================
  // register offsets
  localparam logic [7:0] TIMER_COUNT_ADDR  = 8'h01;
  localparam logic [7:0] COMP_CTRL_ADDR    = 8'h07;
  localparam logic [7:0] PRESCALE_CFG_ADDR = 8'h20;
  localparam logic [7:0] PIN_DIR_ADDR      = 8'h21;

  // ==============================
  // reset values
  localparam logic [7:0] TIMER_COUNT_RST  = 8'h00;
  localparam logic [6:0] COMP_CTRL_RST    = 7'h7f;
  localparam logic [7:0] PRESCALE_CFG_RST = 8'hff;
  localparam logic [3:0] PIN_DIR_RST      = 4'hf;
  localparam logic [7:0] PRESCALER_RST    = 8'h00;

  // ==============================
  // field positions
  localparam int CFG_SRC_BIT     = 5;
  localparam int CFG_EDGE_BIT    = 4;
  localparam int CFG_ASSIGN_BIT  = 3;
  localparam int CFG_RATIO_LSB   = 0;
  localparam int CMC_OUT_BIT     = 7;
  localparam int CMC_OUT_DIS_BIT = 6;
  localparam int CMC_CLK_SEL_BIT = 4;
  localparam int DIR_COUNT_PIN   = 2;

  // ==============================
  // types
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tcp_bus_req_type;

  typedef struct packed {
    logic o;
    logic oe;
  } tcp_pin_drv_type;

  typedef enum logic [1:0] {
    SRC_INSTR = 2'b00,
    SRC_COMP  = 2'b01,
    SRC_PIN   = 2'b10
  } tcp_src_type;

endpackage

/* logic/tcp_timer.sv */
// timer/counter with shared prescaler, register port and assertions
//
// Overview of operation
// - source select 0 counts each instruction cycle when the prescaler is watchdog-assigned
// - count write blocks increments for two cycles
// - source select and comparator clock select both high count the pin
// - edge select 0 rising, 1 falling edge
// - comparator clock select 0 counts comparator output
// - output disable 0 drives comparator onto pin
// - source select 1 overrides pin direction control
// - prescaler serves counter or watchdog, never both
// - counter ratios run from 1:2 to 1:256
// - prescaler is 8 bits, hidden from software
// - count register is 8 bits, read/write
// - external clock divided by prescaler, symmetric output
// - divided source sampled on Q2 and Q4
// - increment 3 to 7 Tosc after edge
// - count writes clear prescaler when counter-assigned
// - watchdog clear clears prescaler and watchdog when watchdog-assigned
// - reset leaves prescaler at all zeros
// - output disable 0 routes comparator to pin
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/10ps

module tcp_timer
  import tcp_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire tcp_bus_req_type  bus_req,
  output logic [7:0]            rdata,
  input  wire logic             comp_out,
  input  wire logic             count_clock_pin_in,
  output tcp_pin_drv_type       count_clock_pin_drv,
  input  wire logic             pin_latch_data,
  input  wire logic             watchdog_clear_instruction,
  input  wire logic             watchdog_tick,
  output logic                  watchdog_counter_clear,
  output logic                  watchdog_postscale_tick,
  output logic [7:0]            timer_count
);

  // ==============================
  // state
  logic [1:0]      q_reg;
  logic [7:0]      count_reg;
  logic [7:0]      count_next;
  logic [7:0]      cfg_reg;
  logic [6:0]      cmc_reg;
  logic [3:0]      dir_reg;
  logic [7:0]      pre_reg;
  logic [7:0]      pre_next;
  logic [1:0]      inh_reg;
  logic [1:0]      inh_next;
  logic            ext_prev_reg;
  logic            sel_prev_reg;
  logic            samp_reg;
  logic            samp_prev_reg;
  logic [7:0]      rdata_reg;
  logic [7:0]      rdata_next;
  logic            wd_clr_reg;
  logic            wd_tick_reg;
  logic            wd_tick_next;
  tcp_pin_drv_type pin_reg;
  tcp_pin_drv_type pin_next;

  // ==============================
  // bus decode
  wire wr_timer = bus_req.wr && (bus_req.addr == TIMER_COUNT_ADDR);
  wire wr_cmc   = bus_req.wr && (bus_req.addr == COMP_CTRL_ADDR);
  wire wr_cfg   = bus_req.wr && (bus_req.addr == PRESCALE_CFG_ADDR);
  wire wr_dir   = bus_req.wr && (bus_req.addr == PIN_DIR_ADDR);
  wire rd_timer = bus_req.addr == TIMER_COUNT_ADDR;
  wire rd_cmc   = bus_req.addr == COMP_CTRL_ADDR;

  // ==============================
  // configuration fields
  wire       src_sel   = cfg_reg[CFG_SRC_BIT];
  wire       edge_sel  = cfg_reg[CFG_EDGE_BIT];
  wire       to_wdog   = cfg_reg[CFG_ASSIGN_BIT];
  wire [2:0] ratio     = cfg_reg[CFG_RATIO_LSB +: 3];
  wire       cmp_clk   = cmc_reg[CMC_CLK_SEL_BIT];
  wire       cmp_out_n = cmc_reg[CMC_OUT_DIS_BIT];

  // ==============================
  // quarter phases
  wire instr_end = q_reg == PH_Q4;
  wire sample_pt = (q_reg == PH_Q2) || (q_reg == PH_Q4);

  // ==============================
  // count source selection
  tcp_src_type src_mode;
  logic        ext_raw;

  assign src_mode = !src_sel ? SRC_INSTR :
                    !cmp_clk ? SRC_COMP :
                               SRC_PIN;

  // in the fed-back case the pin carries the comparator, so SRC_PIN covers it
  always_comb begin
    case (src_mode)
      SRC_COMP: ext_raw = comp_out;
      SRC_PIN:  ext_raw = count_clock_pin_in;
      default:  ext_raw = 1'b0;
    endcase
  end

  // a falling edge is turned into a rising one by inversion
  wire ext_pol  = ext_raw ^ edge_sel;
  wire ext_rise = ext_pol && !ext_prev_reg;
  wire ext_mode = src_mode != SRC_INSTR;

  // ==============================
  // shared prescaler
  // one counter, steered by the assign bit; the other user never sees it
  wire pre_evt = to_wdog  ? watchdog_tick :
                 ext_mode ? ext_rise : instr_end;
  wire pre_clr = to_wdog ? watchdog_clear_instruction
                         : wr_timer;

  // counter side taps bit n (2^(n+1)), watchdog side bit n-1 (2^n)
  wire [2:0] sel_idx  = to_wdog ? 3'(ratio - 3'h1) : ratio;
  wire       sel_bit  = pre_reg[sel_idx];
  wire       sel_rise = sel_bit && !sel_prev_reg;

  // synchronous stand-in for the ripple divider; bit n is still a
  // square wave, so the sampler sees a symmetric signal
  always_comb begin
    pre_next = pre_reg;
    if (pre_clr) begin
      pre_next = PRESCALER_RST;
    end else if (pre_evt) begin
      pre_next = 8'(pre_reg + 8'h01);
    end
  end

  assign wd_tick_next = to_wdog &&
                        ((ratio == 3'h0) ? watchdog_tick : sel_rise);

  // ==============================
  // q2/q4 sampler
  // limitation: an input shorter than two quarters can be missed
  wire samp_src  = to_wdog ? ext_pol : sel_bit;
  wire samp_rise = sample_pt && samp_reg && !samp_prev_reg;

  // ==============================
  // count register
  wire count_evt = ext_mode ? samp_rise :
                   to_wdog  ? instr_end :
                              sel_rise;
  wire inhibited = inh_reg != 2'h0;

  always_comb begin
    count_next = count_reg;
    if (wr_timer) begin
      count_next = bus_req.wdata;
    end else if (count_evt && !inhibited) begin
      count_next = 8'(count_reg + 8'h01);
    end
  end

  always_comb begin
    inh_next = inh_reg;
    if (wr_timer) begin
      inh_next = WR_INHIBIT_CYCLES;
    end else if (instr_end && inhibited) begin
      inh_next = 2'(inh_reg - 2'h1);
    end
  end

  // ==============================
  // pin steering
  // output disable low wins over the direction latch and source select
  always_comb begin
    if (!cmp_out_n) begin
      pin_next.o  = comp_out;
      pin_next.oe = 1'b1;
    end else begin
      pin_next.o  = pin_latch_data;
      pin_next.oe = !src_sel && !dir_reg[DIR_COUNT_PIN];
    end
  end

  // ==============================
  // read path
  // write-only registers read as zero
  assign rdata_next = !bus_req.rd ? 8'h00 :
                      rd_timer    ? count_reg :
                      rd_cmc      ? {comp_out, cmc_reg} :
                                    8'h00;

  // ==============================
  // flip-flops
  always_ff @(posedge mclk) begin
    if (rst) begin
      q_reg <= 2'h0;
    end else begin
      q_reg <= 2'(q_reg + 2'h1);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg_reg <= PRESCALE_CFG_RST;
      cmc_reg <= COMP_CTRL_RST;
      dir_reg <= PIN_DIR_RST;
    end else begin
      if (wr_cfg) begin
        cfg_reg <= bus_req.wdata;
      end
      if (wr_cmc) begin
        cmc_reg <= bus_req.wdata[6:0];
      end
      if (wr_dir) begin
        dir_reg <= bus_req.wdata[3:0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      // previous levels start high: an idle high pin must not look like an edge
      pre_reg      <= PRESCALER_RST;
      sel_prev_reg <= 1'b1;
      ext_prev_reg <= 1'b1;
    end else begin
      pre_reg      <= pre_next;
      sel_prev_reg <= sel_bit;
      ext_prev_reg <= ext_pol;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      // both high, so the first count needs a sampled low before a high
      samp_reg      <= 1'b1;
      samp_prev_reg <= 1'b1;
    end else if (sample_pt) begin
      samp_reg      <= samp_src;
      samp_prev_reg <= samp_reg;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      count_reg <= TIMER_COUNT_RST;
      inh_reg   <= 2'h0;
    end else begin
      count_reg <= count_next;
      inh_reg   <= inh_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_reg   <= 8'h00;
      wd_clr_reg  <= 1'b0;
      wd_tick_reg <= 1'b0;
      pin_reg     <= '0;
    end else begin
      rdata_reg   <= rdata_next;
      wd_clr_reg  <= to_wdog && watchdog_clear_instruction;
      wd_tick_reg <= wd_tick_next;
      pin_reg     <= pin_next;
    end
  end

  assign rdata                   = rdata_reg;
  assign timer_count             = count_reg;
  assign watchdog_counter_clear  = wd_clr_reg;
  assign watchdog_postscale_tick = wd_tick_reg;
  assign count_clock_pin_drv     = pin_reg;

  // ==============================
  // assertions
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  property p_timer_mode;
    !src_sel && to_wdog && instr_end && !inhibited && !wr_timer
      |=> count_reg == 8'($past(count_reg) + 8'h01);
  endproperty
  a_timer_mode: assert property (p_timer_mode)
    else $error("timer mode did not count the instruction cycle");

  property p_wr_inhibit;
    wr_timer ##1 (!wr_timer) [*3] |-> count_reg == $past(bus_req.wdata, 3);
  endproperty
  a_wr_inhibit: assert property (p_wr_inhibit)
    else $error("count moved inside the write inhibit window");

  property p_ext_inc;
    ext_mode && samp_rise && !inhibited && !wr_timer
      |=> count_reg == 8'($past(count_reg) + 8'h01);
  endproperty
  a_ext_inc: assert property (p_ext_inc)
    else $error("sampled source edge was not counted");

  property p_sample_hold;
    !sample_pt |=> $stable(samp_reg) && $stable(samp_prev_reg);
  endproperty
  a_sample_hold: assert property (p_sample_hold)
    else $error("sampler moved outside q2 and q4");

  property p_pre_clr_write;
    wr_timer && !to_wdog |=> pre_reg == PRESCALER_RST;
  endproperty
  a_pre_clr_write: assert property (p_pre_clr_write)
    else $error("count write did not clear the prescaler");

  property p_wd_clear;
    to_wdog && watchdog_clear_instruction
      |=> pre_reg == PRESCALER_RST && watchdog_counter_clear;
  endproperty
  a_wd_clear: assert property (p_wd_clear)
    else $error("watchdog clear missed prescaler or watchdog");

  property p_reset_pre;
    $fell(rst) |-> pre_reg == PRESCALER_RST;
  endproperty
  a_reset_pre: assert property (p_reset_pre)
    else $error("prescaler not zero after reset");

  property p_dir_override;
    src_sel && cmp_out_n |=> !count_clock_pin_drv.oe;
  endproperty
  a_dir_override: assert property (p_dir_override)
    else $error("pin driven while counting from it");

  property p_comp_pin;
    !cmp_out_n |=> count_clock_pin_drv.oe && count_clock_pin_drv.o == $past(comp_out);
  endproperty
  a_comp_pin: assert property (p_comp_pin)
    else $error("comparator not routed onto the pin");

  property p_ratio_hold;
    !src_sel && !to_wdog && !sel_rise && !wr_timer |=> $stable(count_reg);
  endproperty
  a_ratio_hold: assert property (p_ratio_hold)
    else $error("count moved without a prescaler output edge");

  property p_wr_load;
    wr_timer |=> timer_count == $past(bus_req.wdata);
  endproperty
  a_wr_load: assert property (p_wr_load)
    else $error("count write did not land");

  property p_rdata_idle;
    !bus_req.rd |=> rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data stood outside the read answer cycle");

  property p_post_quiet;
    !to_wdog |=> !watchdog_postscale_tick && !watchdog_counter_clear;
  endproperty
  a_post_quiet: assert property (p_post_quiet)
    else $error("watchdog served while prescaler belongs to the counter");

  property p_pre_hold;
    !pre_evt && !pre_clr |=> $stable(pre_reg);
  endproperty
  a_pre_hold: assert property (p_pre_hold)
    else $error("prescaler moved without an input event");

  // fed-back comparator: the pin both carries and counts the comparator
  property p_fb_source;
    src_mode == SRC_PIN && !cmp_out_n |-> ext_raw == count_clock_pin_in;
  endproperty
  a_fb_source: assert property (p_fb_source)
    else $error("fed-back pin not used as count source");

  c_wrap:     cover property (count_reg == 8'hff ##1 count_reg == 8'h00);
  c_ext_inc:  cover property (ext_mode && samp_rise && !inhibited);
  c_wd_clear: cover property (to_wdog && watchdog_clear_instruction);
  c_write:    cover property (wr_timer ##4 count_evt);
  c_feedback: cover property (src_mode == SRC_PIN && !cmp_out_n && samp_rise);

endmodule

/* test/tb.sv */
// self-checking bench: timer/counter with prescaler against a count model
`timescale 1ns/10ps

module tb
  import tcp_pkg::*;
;
  logic            mclk = 1'b0;
  logic            rst;
  tcp_bus_req_type bus_req;
  logic [7:0]      rdata;
  logic            comp_out;
  logic            pin_level;
  tcp_pin_drv_type pin_drv;
  logic            pin_latch;
  logic            wd_clr;
  logic            wd_tick;
  logic            wd_cnt_clr;
  logic            wd_post;
  logic [7:0]      cnt;
  int              error_cnt = 0;
  int              checked   = 0;
  int              m_cnt;
  int              n_post;
  int              n_clr;
  int              a;

  always #5 mclk = ~mclk;

  tcp_timer i_dut (
    .mclk(mclk), .rst(rst), .bus_req(bus_req), .rdata(rdata), .comp_out(comp_out),
    .count_clock_pin_in(pin_level), .count_clock_pin_drv(pin_drv),
    .pin_latch_data(pin_latch), .watchdog_clear_instruction(wd_clr),
    .watchdog_tick(wd_tick), .watchdog_counter_clear(wd_cnt_clr),
    .watchdog_postscale_tick(wd_post), .timer_count(cnt)
  );
  tcp_src_model i_src (
    .mclk(mclk), .pin_drv(pin_drv), .pin_level(pin_level), .comp_out(comp_out)
  );

  // counted mid-cycle so a clear from the main thread never races the update
  always @(negedge mclk) begin
    n_post <= n_post + int'(wd_post);
    n_clr  <= n_clr + int'(wd_cnt_clr);
  end

  // ==============================
  // tasks
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // even n leaves the tick low, so it never stands longer than one cycle
  task automatic cyc(input int n, input logic t);
    repeat (n) begin
      @(posedge mclk);
      wd_tick <= t & ~wd_tick;
    end
    #1;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
    @(posedge mclk);
    bus_req <= '{1'b1, 1'b0, ad, dt};
    @(posedge mclk);
    bus_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
    @(posedge mclk);
    bus_req <= '{1'b0, 1'b1, ad, 8'h00};
    @(posedge mclk);
    bus_req.rd <= 1'b0;
    #1;
    chk8(rdata, exp);
  endtask

  task automatic clr_wd();
    @(posedge mclk);
    wd_clr <= 1'b1;
    @(posedge mclk);
    wd_clr <= 1'b0;
  endtask

  task automatic to_wd();
    clr_wd();
    wr(TIMER_COUNT_ADDR, 8'h00);
    wr(PRESCALE_CFG_ADDR, 8'h0f);
    clr_wd();
  endtask

  // count must stay put for two mclk and be updated by the seventh
  task automatic edge_chk(input logic s, input logic v, input int inc);
    a = cnt;
    i_src.level(s, v);
    #1;
    chk8(cnt, 8'(a));
    m_cnt = a + inc;
    cyc(5, 1'b0);
    chk8(cnt, 8'(m_cnt));
  endtask

  task automatic end_sim();
    $display("mismatches %0d of %0d checks", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge mclk);
    error_cnt++;
    end_sim();
  end

  // ==============================
  // main sequence
  initial begin
    void'($urandom(32'h2101));
    rst = 1'b1;
    bus_req = '0;
    pin_latch = 1'b0;
    wd_clr = 1'b0;
    wd_tick = 1'b0;
    n_post = 0;
    n_clr = 0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    cyc(1, 1'b0);
    chk8(cnt, TIMER_COUNT_RST);
    chk8({7'h00, pin_drv.oe}, 8'h00);
    rd(COMP_CTRL_ADDR, {comp_out, COMP_CTRL_RST});
    rd(PRESCALE_CFG_ADDR, 8'h00);
    rd(8'h33, 8'h00);
    chk8(cnt, TIMER_COUNT_RST);
    wr(PRESCALE_CFG_ADDR, 8'h08);
    for (int i = 0; i < 3; i++) begin
      m_cnt = (i == 2) ? 32'h0000_00fa : int'($urandom % 256);
      wr(TIMER_COUNT_ADDR, 8'(m_cnt));
      rd(TIMER_COUNT_ADDR, 8'(m_cnt));
      m_cnt = m_cnt + 8;
      cyc(38, 1'b1);
      chk8(cnt, 8'(m_cnt));
      cyc(40, 1'b0);
      chk8(cnt, 8'(m_cnt + 10));
    end
    n_clr = 0;
    for (int n = 0; n < 8; n++) begin
      clr_wd();
      wr(PRESCALE_CFG_ADDR, 8'(n));
      wr(TIMER_COUNT_ADDR, 8'h00);
      cyc((4 << n) - 4, 1'b0);
      chk8(cnt, 8'h00);
      cyc(16 << n, 1'b0);
      a = cnt;
      n_post = 0;
      cyc(16 << n, 1'b1);
      m_cnt = a + 2;
      chk8(cnt, 8'(m_cnt));
      chk8(8'(n_post), 8'h00);
    end
    chk8(8'(n_clr), 8'h01);
    to_wd();
    for (int n = 0; n < 4; n++) begin
      wr(PRESCALE_CFG_ADDR, 8'h08 | 8'(n));
      n_clr = 0;
      clr_wd();
      cyc(2, 1'b0);
      chk8(8'(n_clr), 8'h01);
      n_post = 0;
      cyc(4 << n, 1'b1);
      cyc(4, 1'b0);
      chk8(8'(n_post), 8'h02);
    end
    for (int e = 0; e < 2; e++) begin
      wr(PRESCALE_CFG_ADDR, 8'h28 | 8'(e << 4));
      cyc(8, 1'b0);
      edge_chk(1'b0, 1'b1, 1 - e);
      edge_chk(1'b0, 1'b0, e);
    end
    clr_wd();
    wr(PRESCALE_CFG_ADDR, 8'h20);
    wr(TIMER_COUNT_ADDR, 8'h00);
    cyc(12, 1'b0);
    repeat (4) begin
      i_src.level(1'b0, 1'b1);
      i_src.level(1'b0, 1'b0);
    end
    cyc(8, 1'b0);
    chk8(cnt, 8'h02);
    to_wd();
    wr(PRESCALE_CFG_ADDR, 8'h28);
    for (int k = 0; k < 2; k++) begin
      wr(COMP_CTRL_ADDR, (k == 1) ? 8'h2f : 8'h6f);
      cyc(8, 1'b0);
      edge_chk(1'b1, 1'b1, 1);
      edge_chk(1'b1, 1'b0, 0);
    end
    chk8({7'h00, pin_drv.oe}, 8'h01);
    i_src.drive(1'b0);
    wr(COMP_CTRL_ADDR, 8'h3f);
    cyc(8, 1'b0);
    a = cnt;
    i_src.level(1'b1, 1'b1);
    cyc(8, 1'b0);
    chk8({6'h00, pin_drv.oe, pin_drv.o}, 8'h03);
    chk8(cnt, 8'(a + 1));
    i_src.level(1'b1, 1'b0);
    wr(PIN_DIR_ADDR, 8'h00);
    wr(COMP_CTRL_ADDR, 8'h7f);
    cyc(2, 1'b0);
    chk8({7'h00, pin_drv.oe}, 8'h00);
    @(posedge mclk);
    pin_latch <= 1'($urandom);
    wr(PRESCALE_CFG_ADDR, 8'h08);
    cyc(2, 1'b0);
    chk8({6'h00, pin_drv.oe, pin_drv.o}, {6'h00, 1'b1, pin_latch});
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    cyc(1, 1'b0);
    chk8(cnt, TIMER_COUNT_RST);
    chk8({7'h00, pin_drv.oe}, 8'h00);
    end_sim();
  end
endmodule

/* test/tcp_src_model.sv */
// count source model: external count pin and comparator level
`timescale 1ns/10ps

// ==============================
// source model
module tcp_src_model
  import tcp_pkg::*;
(
  input  wire logic            mclk,
  input  wire tcp_pin_drv_type pin_drv,
  output logic                 pin_level,
  output logic                 comp_out
);
  logic ext_val = 1'b0;
  logic ext_en  = 1'b1;
  logic flt     = 1'b0;

  initial begin
    comp_out = 1'b0;
  end

  // no pull on the pin: a released wire keeps moving so a stale level is never trusted
  always @(posedge mclk) begin
    flt <= ~flt;
  end
  assign pin_level = pin_drv.oe ? pin_drv.o : (ext_en ? ext_val : flt);

  // each change is held at least two mclk before the next one
  task automatic level(input logic sel, input logic v);
    @(posedge mclk);
    if (sel) begin
      comp_out <= v;
    end else begin
      ext_val <= v;
    end
    repeat (2) @(posedge mclk);
  endtask

  task automatic drive(input logic en);
    @(posedge mclk);
    ext_en <= en;
  endtask
endmodule
